// file: design/code_classifier.sv
`timescale 1ns/10ps
module code_classifier
  import code_decoder_pkg::*;
(
  input wire logic [7:0] code,
  output msg_class_t msg_class,
  output logic defined_cmd
);

  always_comb
  begin
    msg_class = CLS_RESERVED;
    defined_cmd = 1'b0;
    if (code >= NETVAR_FIRST)
    begin
      msg_class = CLS_NETVAR;
    end
    else if (code == SERVICE_PIN)
    begin
      msg_class = CLS_SERVICE;
    end
    else if (code >= ROUTER_FIRST)
    begin
      msg_class = CLS_ROUTER;
    end
    else if (code >= MGMT_FIRST)
    begin
      msg_class = CLS_MGMT;
      defined_cmd = (code >= MGMT_CMD_FIRST);
    end
    else if (code >= DIAG_FIRST)
    begin
      msg_class = CLS_DIAG;
      defined_cmd = (code >= DIAG_CMD_FIRST) && (code <= DIAG_CMD_LAST);
    end
    else if (code >= FOREIGN_FIRST && code <= FOREIGN_LAST)
    begin
      msg_class = CLS_FOREIGN;
    end
    else if (code <= APPL_LAST)
    begin
      msg_class = CLS_APPL;
    end
  end

endmodule

// file: design/code_decoder_pkg.sv
package code_decoder_pkg;

  // Message classes
  typedef enum logic [7:0] {
    CLS_NONE = 8'h00,
    CLS_APPL = 8'h01,
    CLS_FOREIGN = 8'h02,
    CLS_DIAG = 8'h04,
    CLS_MGMT = 8'h08,
    CLS_ROUTER = 8'h10,
    CLS_SERVICE = 8'h20,
    CLS_NETVAR = 8'h40,
    CLS_RESERVED = 8'h80
  } msg_class_t;

  // Delivery services
  typedef enum logic [1:0] {
    SVC_ACKD = 2'h0,
    SVC_UNACKD_RPT = 2'h1,
    SVC_UNACKD = 2'h2,
    SVC_REQUEST = 2'h3
  } service_t;

  // Code range limits
  localparam logic [7:0] APPL_LAST = 8'h3e;
  localparam logic [7:0] FOREIGN_FIRST = 8'h40;
  localparam logic [7:0] FOREIGN_LAST = 8'h4e;
  localparam logic [7:0] DIAG_FIRST = 8'h50;
  localparam logic [7:0] DIAG_LAST = 8'h5f;
  localparam logic [7:0] MGMT_FIRST = 8'h60;
  localparam logic [7:0] MGMT_LAST = 8'h73;
  localparam logic [7:0] ROUTER_FIRST = 8'h74;
  localparam logic [7:0] ROUTER_LAST = 8'h7e;
  localparam logic [7:0] SERVICE_PIN = 8'h7f;
  localparam logic [7:0] NETVAR_FIRST = 8'h80;

  // Defined command spans
  localparam logic [7:0] DIAG_CMD_FIRST = 8'h51;
  localparam logic [7:0] DIAG_CMD_LAST = 8'h54;
  localparam logic [7:0] MGMT_CMD_FIRST = 8'h61;

  // Off-line answers
  localparam logic [7:0] APPL_OFFLINE_RESP = 8'h3f;
  localparam logic [7:0] FOREIGN_OFFLINE_RESP = 8'h4f;

  // Response offsets
  localparam logic [7:0] MGMT_OK_DELTA = 8'h40;
  localparam logic [7:0] MGMT_FAIL_DELTA = 8'h60;
  localparam logic [7:0] DIAG_OK_DELTA = 8'h20;
  localparam logic [7:0] DIAG_FAIL_DELTA = 8'h40;
  localparam logic [7:0] ROUTER_OK_DELTA = 8'h40;
  localparam logic [7:0] ROUTER_FAIL_DELTA = 8'h60;

  // Individual commands
  localparam logic [7:0] CMD_QUERY_STATUS = 8'h51;
  localparam logic [7:0] CMD_PROXY = 8'h52;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h53;
  localparam logic [7:0] CMD_QUERY_ID = 8'h61;
  localparam logic [7:0] CMD_RESPOND_QUERY = 8'h62;
  localparam logic [7:0] CMD_UPDATE_DOMAIN = 8'h63;
  localparam logic [7:0] CMD_LEAVE_DOMAIN = 8'h64;
  localparam logic [7:0] CMD_UPDATE_KEY = 8'h65;
  localparam logic [7:0] CMD_UPDATE_ADDR = 8'h66;
  localparam logic [7:0] CMD_UPDATE_GROUP = 8'h69;
  localparam logic [7:0] CMD_UPDATE_NV_CFG = 8'h6b;
  localparam logic [7:0] CMD_SET_MODE = 8'h6c;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h6e;
  localparam logic [7:0] CMD_CHECKSUM = 8'h6f;
  localparam logic [7:0] CMD_WINK = 8'h70;
  localparam logic [7:0] CMD_MEM_REFRESH = 8'h71;

  // Set-mode sub-codes that get no response at all
  localparam logic [7:0] MODE_OFFLINE = 8'h00;
  localparam logic [7:0] MODE_ONLINE = 8'h01;

  // Extended receive timer
  localparam int CLOCK_HZ = 50_000_000;
  localparam int EXT_RX_TIMER_S = 8;
  localparam logic [31:0] EXT_RX_TIMER_CYCLES =
    32'(EXT_RX_TIMER_S * CLOCK_HZ);

endpackage

// file: design/net_mgmt_code_decoder.sv
// Functional notes
// - Classify message code into seven code ranges
// - Off-line answers application 0x3F, foreign 0x4F
// - Response codes stay within per-class ranges
// - Management and diagnostic response offsets
// - Wink and set-mode on/off-line: no response
// - No-data management commands accept any service
// - Authenticate if bit set, except exempt commands
// - Unconfigured node ignores authentication bit
// - Unprocessable command returns failed response
// - Application node fails every router request
// - Identifier-addressed management extends rx timer 8s
// - Network variable codes bypass explicit path
// - Auth bit rejects unauthenticated configuration
`timescale 1ns/10ps
module net_mgmt_code_decoder
  import code_decoder_pkg::*;
#(
  parameter logic [31:0] EXT_RX_CYCLES = EXT_RX_TIMER_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic [7:0] msg_code,
  input wire logic [7:0] msg_first_data,
  input wire logic [1:0] msg_service,
  input wire logic msg_authenticated,
  input wire logic msg_id_addressed,
  input wire logic node_offline,
  input wire logic node_configured,
  input wire logic node_is_router,
  input wire logic mgmt_auth_required,
  input wire logic cmd_failed,
  output logic dec_valid,
  output msg_class_t dec_class,
  output logic dec_explicit,
  output logic dec_execute,
  output logic dec_rejected,
  output logic resp_valid,
  output logic [7:0] resp_code,
  output logic rx_timer_extended
);

  msg_class_t cls;
  logic defined_cmd;
  logic needs_auth;
  logic exempt;
  logic no_resp_data;
  logic silent;
  logic service_ok;
  logic fail;
  logic give_resp;
  logic [7:0] resp_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;

  code_classifier u_classifier
  (
    .code(msg_code),
    .msg_class(cls),
    .defined_cmd(defined_cmd)
  );

  // Commands with no response data
  always_comb
  begin
    case (msg_code)
      CMD_RESPOND_QUERY, CMD_UPDATE_DOMAIN, CMD_LEAVE_DOMAIN,
      CMD_UPDATE_KEY, CMD_UPDATE_ADDR, CMD_UPDATE_GROUP,
      CMD_UPDATE_NV_CFG, CMD_SET_MODE, CMD_WRITE_MEM,
      CMD_CHECKSUM, CMD_MEM_REFRESH, CMD_CLEAR_STATUS, CMD_WINK:
        no_resp_data = 1'b1;
      default:
        no_resp_data = 1'b0;
    endcase
  end

  // Authentication
  always_comb
  begin
    exempt = (msg_code == CMD_QUERY_ID) ||
             (msg_code == CMD_RESPOND_QUERY) ||
             (msg_code == CMD_QUERY_STATUS) ||
             (msg_code == CMD_PROXY);
    needs_auth = mgmt_auth_required && node_configured && !exempt &&
                 (cls == CLS_MGMT || cls == CLS_DIAG);
  end

  // Service and response selection
  always_comb
  begin
    silent = (msg_code == CMD_WINK) ||
             ((msg_code == CMD_SET_MODE) &&
              (msg_first_data == MODE_OFFLINE ||
               msg_first_data == MODE_ONLINE));
    service_ok = (msg_service == SVC_REQUEST) || no_resp_data;
    fail = cmd_failed || !service_ok ||
           ((cls == CLS_MGMT || cls == CLS_DIAG) && !defined_cmd);
    give_resp = msg_service == SVC_REQUEST;
    resp_next = 8'h00;
    case (cls)
      CLS_MGMT:
      begin
        resp_next = fail ? msg_code - MGMT_FAIL_DELTA
                         : msg_code - MGMT_OK_DELTA;
        give_resp = give_resp && !silent;
      end
      CLS_DIAG:
        resp_next = fail ? msg_code - DIAG_FAIL_DELTA
                         : msg_code - DIAG_OK_DELTA;
      CLS_ROUTER:
        resp_next = (node_is_router && !cmd_failed)
                    ? msg_code - ROUTER_OK_DELTA
                    : msg_code - ROUTER_FAIL_DELTA;
      CLS_APPL:
      begin
        resp_next = APPL_OFFLINE_RESP;
        give_resp = give_resp && node_offline;
      end
      CLS_FOREIGN:
      begin
        resp_next = FOREIGN_OFFLINE_RESP;
        give_resp = give_resp && node_offline;
      end
      default:
        give_resp = 1'b0;
    endcase
    if ((cls == CLS_MGMT || cls == CLS_DIAG) && needs_auth &&
        !msg_authenticated)
    begin
      give_resp = 1'b0;
    end
  end

  // Decode outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_valid <= 1'b0;
      dec_class <= CLS_NONE;
      dec_explicit <= 1'b0;
      dec_execute <= 1'b0;
      dec_rejected <= 1'b0;
    end
    else
    begin
      dec_valid <= msg_valid;
      dec_class <= msg_valid ? cls : CLS_NONE;
      dec_explicit <= msg_valid && (cls == CLS_APPL ||
                      cls == CLS_FOREIGN);
      dec_rejected <= msg_valid && needs_auth &&
                      !msg_authenticated;
      dec_execute <= msg_valid && (cls == CLS_MGMT || cls == CLS_DIAG ||
                     cls == CLS_ROUTER) &&
                     !(needs_auth && !msg_authenticated) && !fail &&
                     (cls != CLS_ROUTER || node_is_router);
    end
  end

  // Response outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp_code <= 8'h00;
    end
    else
    begin
      resp_valid <= msg_valid && give_resp;
      if (msg_valid && give_resp)
      begin
        resp_code <= resp_next;
      end
    end
  end

  // Extended receive transaction timer
  always_comb
  begin
    timer_next = timer_reg;
    if (msg_valid && msg_id_addressed &&
        (cls == CLS_MGMT || cls == CLS_DIAG))
    begin
      timer_next = EXT_RX_CYCLES;
    end
    else if (timer_reg != 32'h0)
    begin
      timer_next = timer_reg - 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_reg <= 32'h0;
      rx_timer_extended <= 1'b0;
    end
    else
    begin
      timer_reg <= timer_next;
      rx_timer_extended <= (timer_next != 32'h0);
    end
  end

endmodule

// file: tb/dec_properties.sv
`timescale 1ns/10ps
module dec_properties
  import code_decoder_pkg::*;
#(
  parameter logic [31:0] EXT_RX_CYCLES = 32'h0000000a
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic [7:0] msg_code,
  input wire logic [1:0] msg_service,
  input wire logic msg_authenticated,
  input wire logic msg_id_addressed,
  input wire logic node_offline,
  input wire logic node_configured,
  input wire logic node_is_router,
  input wire logic mgmt_auth_required,
  input wire logic cmd_failed,
  input wire logic dec_valid,
  input wire msg_class_t dec_class,
  input wire logic dec_explicit,
  input wire logic dec_rejected,
  input wire logic resp_valid,
  input wire logic [7:0] resp_code,
  input wire logic rx_timer_extended
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic req;
  logic plain;
  assign req = msg_valid && msg_service == 2'h3;
  assign plain = req && !node_configured;
  sequence answered;
    dec_valid && resp_valid;
  endsequence
  sequence ext_run;
    rx_timer_extended [*8];
  endsequence
  answer_delay_a: assert property (msg_valid |=> dec_valid)
    else $error("late decode");
  netvar_path_a: assert property (msg_valid && msg_code[7] |=>
    dec_class == CLS_NETVAR && !dec_explicit && !resp_valid)
    else $error("netvar leaked");
  mgmt_ok_a: assert property (plain && !cmd_failed &&
    msg_code inside {[8'h61:8'h6b], [8'h6d:8'h6f], [8'h71:8'h73]}
    |=> answered ##0 resp_code == $past(msg_code) - 8'h40)
    else $error("bad success code");
  mgmt_fail_a: assert property (plain && cmd_failed &&
    msg_code inside {[8'h60:8'h6b], [8'h6d:8'h6f], [8'h71:8'h73]}
    |=> answered ##0 resp_code == $past(msg_code) - 8'h60)
    else $error("bad failure code");
  wink_quiet_a: assert property (msg_valid && msg_code == CMD_WINK
    |=> !resp_valid)
    else $error("wink answered");
  auth_reject_a: assert property (msg_valid && mgmt_auth_required &&
    node_configured && !msg_authenticated &&
    msg_code inside {[8'h63:8'h73]} |=> dec_rejected && !resp_valid)
    else $error("missing reject");
  router_fail_a: assert property (req && !node_is_router &&
    msg_code inside {[8'h74:8'h7e]}
    |=> answered ##0 resp_code == $past(msg_code) - 8'h60)
    else $error("router not failed");
  offline_appl_a: assert property (req && node_offline &&
    msg_code <= 8'h3e |=> answered ##0 resp_code == 8'h3f)
    else $error("no off-line answer");
  timer_ext_a: assert property (msg_valid && msg_id_addressed &&
    msg_code inside {[8'h50:8'h73]} |=> ext_run)
    else $error("timer not extended");
endmodule

bind net_mgmt_code_decoder dec_properties #(
  .EXT_RX_CYCLES(EXT_RX_CYCLES)
) chk (.*);

// file: tb/mgr_model.sv
`timescale 1ns/10ps
module mgr_model (
  input wire logic clock,
  input wire logic resp_valid,
  input wire logic [7:0] resp_code,
  output logic msg_valid = 1'b0,
  output logic [7:0] msg_code = 8'h00,
  output logic [7:0] msg_first_data = 8'h00,
  output logic [1:0] msg_service = 2'h0,
  output logic msg_authenticated = 1'b0,
  output logic msg_id_addressed = 1'b0
);
  logic [7:0] first_resp;
  logic waiting = 1'b0;
  task automatic send(input logic [7:0] c, input logic [1:0] s,
    input logic [7:0] d, input logic au, input logic id);
    @(negedge clock);
    {msg_valid, msg_code, msg_service} = {1'b1, c, s};
    {msg_first_data, msg_authenticated, msg_id_addressed} = {d, au, id};
    @(negedge clock);
    msg_valid = 1'b0;
    msg_code = ~c;
  endtask
  // Only the first reply counts, read against the request sent
  always @(posedge clock)
  begin
    if (resp_valid && waiting)
    begin
      first_resp <= resp_code;
      waiting <= 1'b0;
    end
    if (msg_valid)
    begin
      waiting <= 1'b1;
    end
  end
endmodule

// file: tb/tb_net_mgmt_code_decoder.sv
`timescale 1ns/10ps
module tb_net_mgmt_code_decoder;
  import code_decoder_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic node_offline = 1'b0;
  logic node_configured = 1'b0;
  logic node_is_router = 1'b0;
  logic mgmt_auth_required = 1'b0;
  logic cmd_failed = 1'b0;
  logic msg_valid, msg_authenticated, msg_id_addressed, dec_valid;
  logic dec_explicit, dec_execute, dec_rejected, resp_valid;
  logic rx_timer_extended;
  logic [7:0] msg_code, msg_first_data, resp_code;
  logic [1:0] msg_service;
  msg_class_t dec_class;
  int mismatches = 0;
  int n_compared = 0;
  always #10 clock = ~clock;
  net_mgmt_code_decoder #(.EXT_RX_CYCLES(32'h0000000a)) uut (.*);
  mgr_model pm (.*);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  task automatic tx(input logic [7:0] c);
    pm.send(c, 2'h3, 8'h02, 1'b0, 1'b0);
  endtask
  function automatic logic [7:0] exp_resp(input logic [7:0] c);
    if (c < 8'h60)
      return (cmd_failed || c == 8'h50 || c > 8'h54) ? c - 8'h40 : c - 8'h20;
    return (cmd_failed || c == 8'h60 || c > 8'h73) ? c - 8'h60 : c - 8'h40;
  endfunction
  task automatic t_classes;
    logic [7:0] c[15] = '{8'h00, 8'h3e, 8'h3f, 8'h40, 8'h4e, 8'h4f, 8'h50,
      8'h5f, 8'h60, 8'h73, 8'h74, 8'h7e, 8'h7f, 8'h80, 8'hff};
    logic [7:0] k[15] = '{8'h01, 8'h01, 8'h80, 8'h02, 8'h02, 8'h80, 8'h04,
      8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20, 8'h40, 8'h40};
    for (int i = 0; i < 15; i++)
    begin
      pm.send(c[i], 2'h2, 8'h02, 1'b0, 1'b0);
      chk(dec_class, k[i]);
      chk(dec_valid, 8'h01);
    end
  endtask
  task automatic t_codes;
    for (int f = 0; f < 2; f++)
    begin
      cmd_failed = f[0];
      for (int i = 8'h50; i <= 8'h7e; i++)
        if (i != 8'h70)
        begin
          tx(8'(i));
          chk(resp_valid, 8'h01);
          chk(resp_code, exp_resp(8'(i)));
        end
    end
    cmd_failed = 1'b0;
    node_is_router = 1'b1;
    tx(8'h75);
    chk(resp_code, 8'h35);
    chk(dec_execute, 8'h01);
    node_is_router = 1'b0;
  endtask
  task automatic t_quiet;
    logic [7:0] c[4] = '{CMD_WINK, CMD_SET_MODE, CMD_SET_MODE, 8'h90};
    for (int i = 0; i < 4; i++)
    begin
      pm.send(c[i], 2'h3, 8'(i - 1), 1'b0, 1'b0);
      chk(resp_valid, 8'h00);
    end
    pm.send(CMD_WRITE_MEM, 2'h0, 8'h02, 1'b0, 1'b0);
    chk({dec_execute, resp_valid}, 8'h02);
    repeat (2) @(negedge clock);
    pm.send(8'h6d, 2'h1, 8'h02, 1'b0, 1'b0);
    chk({dec_execute, resp_valid}, 8'h00);
  endtask
  task automatic t_auth;
    mgmt_auth_required = 1'b1;
    node_configured = 1'b1;
    tx(CMD_UPDATE_DOMAIN);
    chk({dec_rejected, resp_valid}, 8'h02);
    tx(CMD_PROXY);
    chk(resp_code, 8'h32);
    pm.send(CMD_UPDATE_DOMAIN, 2'h3, 8'h02, 1'b1, 1'b0);
    chk(resp_code, 8'h23);
    node_configured = 1'b0;
    tx(CMD_QUERY_STATUS);
    tx(CMD_UPDATE_DOMAIN);
    chk({dec_rejected, resp_code == 8'h23}, 8'h01);
    mgmt_auth_required = 1'b0;
  endtask
  task automatic t_offline;
    node_offline = 1'b1;
    tx(8'h10);
    chk(resp_code, 8'h3f);
    tx(8'h45);
    chk(resp_code, 8'h4f);
    node_offline = 1'b0;
    tx(8'h10);
    chk({dec_explicit, resp_valid}, 8'h02);
    chk(pm.first_resp, 8'h4f);
  endtask
  task automatic t_timer;
    chk(rx_timer_extended, 8'h00);
    pm.send(8'h6d, 2'h3, 8'h02, 1'b0, 1'b1);
    repeat (9) @(negedge clock);
    chk(rx_timer_extended, 8'h01);
    @(negedge clock);
    chk(rx_timer_extended, 8'h00);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    t_classes;
    t_codes;
    t_quiet;
    t_auth;
    t_offline;
    t_timer;
    end_sim;
  end
  initial
  begin
    #40000;
    mismatches++;
    end_sim;
  end
endmodule
